//--- include/hpl_pkg.sv
// Shared constants and types for the hub port lamp driver
package hpl_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 25_000_000;
  localparam int SPEED_BLINK_HZ  = 1000;
  // Half period of the high-speed square wave, in clock cycles
  localparam int BLINK_HALF_CYCLES = CLK_HZ / (2 * SPEED_BLINK_HZ);

  // ----------------------------------------------------------------
  // Indicator modes
  // ----------------------------------------------------------------
  typedef enum logic
  {
    HPL_MODE_SPEED,
    HPL_MODE_STATUS
  } hpl_mode_e;

  localparam hpl_mode_e MODE_RESET = HPL_MODE_SPEED;

  // Configuration-select codes that call for port-status lamps
  localparam logic [2:0] CFG_STATUS_CODE_A = 3'h2;
  localparam logic [2:0] CFG_STATUS_CODE_B = 3'h5;
  localparam logic [2:0] CFG_STATUS_CODE_C = 3'h7;

  // ----------------------------------------------------------------
  // Attached device speed, as reported by the hub core
  // ----------------------------------------------------------------
  typedef logic [1:0] hpl_speed_t;
  localparam hpl_speed_t SPEED_LOW  = 2'h0;
  localparam hpl_speed_t SPEED_FULL = 2'h1;
  localparam hpl_speed_t SPEED_HIGH = 2'h2;

  // ----------------------------------------------------------------
  // Port indicator selector, as set by the host per port
  // ----------------------------------------------------------------
  typedef logic [1:0] hpl_ind_t;
  localparam hpl_ind_t IND_AUTO  = 2'h0;
  localparam hpl_ind_t IND_AMBER = 2'h1;
  localparam hpl_ind_t IND_GREEN = 2'h2;
  localparam hpl_ind_t IND_OFF   = 2'h3;

  // ----------------------------------------------------------------
  // Pin reset levels
  // ----------------------------------------------------------------
  localparam logic LAMP_N_RESET  = 1'b1;
  localparam logic LAMP_OE_RESET = 1'b0;

endpackage

//--- include/hpl_lamp_if.sv
// Per-port link between the lamp decision logic and the pin stage
`timescale 1ns/1ns
`default_nettype none

interface hpl_lamp_if;
  hpl_pkg::hpl_mode_e  mode;
  logic                want_green;
  logic                want_amber;
  logic                present;
  logic                suspend;
  logic                square;
  hpl_pkg::hpl_speed_t speed;
  logic                green_n;
  logic                green_oe;
  logic                amber_n;

  modport core
  (
    output mode,
    output want_green,
    output want_amber,
    output present,
    output suspend,
    output square,
    output speed,
    input  green_n,
    input  green_oe,
    input  amber_n
  );

  modport lamp
  (
    input  mode,
    input  want_green,
    input  want_amber,
    input  present,
    input  suspend,
    input  square,
    input  speed,
    output green_n,
    output green_oe,
    output amber_n
  );
endinterface

`default_nettype wire

//--- src/hpl_blink_gen.sv
// Free-running divider for the high-speed square wave
`timescale 1ns/1ns
`default_nettype none

module hpl_blink_gen #(
  parameter int HALF_CYCLES = hpl_pkg::BLINK_HALF_CYCLES
)(
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      square
);

  localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_square;

  // Equal half periods give the nominal fifty percent duty
  always_comb
  begin
    next_count  = count + CW'(1);
    next_square = square;
    if (count >= LAST)
    begin
      next_count  = '0;
      next_square = ~square;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count  <= '0;
      square <= 1'b0;
    end
    else
    begin
      count  <= next_count;
      square <= next_square;
    end
  end

endmodule

`default_nettype wire

//--- src/hpl_port_lamp.sv
// Pin stage for one downstream port: registered lamp levels and enable
`timescale 1ns/1ns
`default_nettype none

module hpl_port_lamp (
  input  wire logic clk,
  input  wire logic sys_rst,
  hpl_lamp_if.lamp  lnk
);

  logic next_green_n;
  logic next_green_oe;
  logic next_amber_n;

  always_comb
  begin
    next_green_n  = hpl_pkg::LAMP_N_RESET;
    next_green_oe = 1'b1;
    next_amber_n  = hpl_pkg::LAMP_N_RESET;
    if (lnk.mode == hpl_pkg::HPL_MODE_STATUS)
    begin
      next_green_n = ~lnk.want_green;
      next_amber_n = ~lnk.want_amber;
    end
    else if (lnk.suspend || !lnk.present)
    begin
      next_green_oe = 1'b0;
    end
    else
    begin
      // Amber pins stay parked high here
      case (lnk.speed)
        hpl_pkg::SPEED_LOW:  next_green_n = 1'b0;
        hpl_pkg::SPEED_FULL: next_green_n = 1'b1;
        hpl_pkg::SPEED_HIGH: next_green_n = lnk.square;
        default:             next_green_oe = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lnk.green_n  <= hpl_pkg::LAMP_N_RESET;
      lnk.green_oe <= hpl_pkg::LAMP_OE_RESET;
      lnk.amber_n  <= hpl_pkg::LAMP_N_RESET;
    end
    else
    begin
      lnk.green_n  <= next_green_n;
      lnk.green_oe <= next_green_oe;
      lnk.amber_n  <= next_amber_n;
    end
  end

endmodule

`default_nettype wire

//--- src/hpl_led_top.sv
// Port indicator lamp driver for a seven-port hub
`timescale 1ns/1ns
`default_nettype none

module hpl_led_top #(
  parameter int NUM_PORTS   = hpl_pkg::NUM_PORTS,
  parameter int HALF_CYCLES = hpl_pkg::BLINK_HALF_CYCLES
)(
  input  wire logic                                clk,
  input  wire logic                                sys_rst,
  input  wire logic                                config_source_select_2,
  input  wire logic                                config_source_select_1,
  input  wire logic                                config_source_select_0,
  input  wire logic                                reg_status_mode_req,
  input  wire logic                                hub_suspend,
  input  wire logic [NUM_PORTS-1:0]                port_power,
  input  wire logic [NUM_PORTS-1:0]                port_connected,
  input  wire logic [NUM_PORTS-1:0]                port_enabled,
  input  wire logic [NUM_PORTS-1:0]                port_error,
  input  wire hpl_pkg::hpl_speed_t [NUM_PORTS-1:0] port_speed,
  input  wire hpl_pkg::hpl_ind_t   [NUM_PORTS-1:0] port_ind_sel,
  output logic [NUM_PORTS-1:0]                     green_port_lamp_n,
  output logic [NUM_PORTS-1:0]                     green_port_lamp_oe,
  output logic [NUM_PORTS-1:0]                     amber_port_lamp_n,
  output logic                                     status_mode_active
);

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  logic [2:0]         cfg_code;
  logic               code_wants_status;
  hpl_pkg::hpl_mode_e mode;
  hpl_pkg::hpl_mode_e next_mode;
  logic               mode_taken;
  logic               next_mode_taken;

  assign cfg_code = {config_source_select_2, config_source_select_1,
                     config_source_select_0};

  always_comb
  begin
    code_wants_status = 1'b0;
    if (cfg_code == hpl_pkg::CFG_STATUS_CODE_A)
    begin
      code_wants_status = 1'b1;
    end
    else if (cfg_code == hpl_pkg::CFG_STATUS_CODE_B)
    begin
      code_wants_status = 1'b1;
    end
    else if (cfg_code == hpl_pkg::CFG_STATUS_CODE_C)
    begin
      code_wants_status = 1'b1;
    end
  end

  // Sampled once, on the first edge after release, so a late register
  // load cannot flip the lamps mid-session
  always_comb
  begin
    next_mode       = mode;
    next_mode_taken = 1'b1;
    if (!mode_taken)
    begin
      if (code_wants_status || reg_status_mode_req)
      begin
        next_mode = hpl_pkg::HPL_MODE_STATUS;
      end
      else
      begin
        next_mode = hpl_pkg::HPL_MODE_SPEED;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode       <= hpl_pkg::MODE_RESET;
      mode_taken <= 1'b0;
    end
    else
    begin
      mode       <= next_mode;
      mode_taken <= next_mode_taken;
    end
  end

  assign status_mode_active = (mode == hpl_pkg::HPL_MODE_STATUS);

  // ----------------------------------------------------------------
  // Square wave source
  // ----------------------------------------------------------------
  logic square;

  hpl_blink_gen #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_blink (
    .clk     (clk),
    .sys_rst (sys_rst),
    .square  (square)
  );

  // ----------------------------------------------------------------
  // Per-port decision and pin stage
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      hpl_lamp_if lnk ();
      logic       auto_green;
      logic       auto_amber;
      logic       sel_green;
      logic       sel_amber;

      // Automatic indicator: fault wins over enabled; dark when unpowered
      // or when nothing is attached and there is no fault. Speed never enters this path.
      always_comb
      begin
        auto_green = 1'b0;
        auto_amber = 1'b0;
        if (!port_power[p])
        begin
          auto_amber = 1'b0;
        end
        else if (port_error[p])
        begin
          auto_amber = 1'b1;
        end
        else if (port_connected[p] && port_enabled[p])
        begin
          auto_green = 1'b1;
        end
      end

      // Host-selected indicator overrides the automatic one
      always_comb
      begin
        sel_green = 1'b0;
        sel_amber = 1'b0;
        case (port_ind_sel[p])
          hpl_pkg::IND_AUTO:
          begin
            sel_green = auto_green;
            sel_amber = auto_amber;
          end
          hpl_pkg::IND_AMBER: sel_amber = 1'b1;
          hpl_pkg::IND_GREEN: sel_green = 1'b1;
          default:            sel_green = 1'b0;
        endcase
      end

      assign lnk.mode       = mode;
      assign lnk.want_green = sel_green;
      assign lnk.want_amber = sel_amber;
      assign lnk.present    = port_connected[p];
      assign lnk.suspend    = hub_suspend;
      assign lnk.square     = square;
      assign lnk.speed      = port_speed[p];

      hpl_port_lamp u_lamp (
        .clk     (clk),
        .sys_rst (sys_rst),
        .lnk     (lnk.lamp)
      );

      assign green_port_lamp_n[p]  = lnk.green_n;
      assign green_port_lamp_oe[p] = lnk.green_oe;
      assign amber_port_lamp_n[p]  = lnk.amber_n;
    end
  endgenerate

endmodule

`default_nettype wire

//--- dv/hpl_led_properties.sv
// Concurrent checks on the lamp driver top ports
`timescale 1ns/1ns
`default_nettype none

module hpl_led_properties #(
  parameter int NUM_PORTS   = 7,
  parameter int HALF_CYCLES = 4
)(
  input wire logic                                clk,
  input wire logic                                sys_rst,
  input wire logic                                config_source_select_2,
  input wire logic                                config_source_select_1,
  input wire logic                                config_source_select_0,
  input wire logic                                reg_status_mode_req,
  input wire logic                                hub_suspend,
  input wire logic [NUM_PORTS-1:0]                port_power,
  input wire logic [NUM_PORTS-1:0]                port_connected,
  input wire logic [NUM_PORTS-1:0]                port_enabled,
  input wire logic [NUM_PORTS-1:0]                port_error,
  input wire hpl_pkg::hpl_speed_t [NUM_PORTS-1:0] port_speed,
  input wire hpl_pkg::hpl_ind_t   [NUM_PORTS-1:0] port_ind_sel,
  input wire logic [NUM_PORTS-1:0]                green_port_lamp_n,
  input wire logic [NUM_PORTS-1:0]                green_port_lamp_oe,
  input wire logic [NUM_PORTS-1:0]                amber_port_lamp_n,
  input wire logic                                status_mode_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [2:0]           cfg;
  logic                 code_hit;
  logic                 speed_mode;
  logic [NUM_PORTS-1:0] live;
  int unsigned          quiet;
  // Cycles since reset release, saturating; wave phase restarts at release
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      quiet <= 0;
    end
    else if (quiet < 1000)
    begin
      quiet <= quiet + 1;
    end
  end
  assign cfg = {config_source_select_2, config_source_select_1, config_source_select_0};
  assign code_hit = (cfg == hpl_pkg::CFG_STATUS_CODE_A) || (cfg == hpl_pkg::CFG_STATUS_CODE_B)
                 || (cfg == hpl_pkg::CFG_STATUS_CODE_C);
  assign speed_mode = !status_mode_active && !sys_rst;
  assign live = speed_mode ? (port_connected & {NUM_PORTS{!hub_suspend}}) : '0;
  sequence s_release;
    $fell(sys_rst);
  endsequence
  AST_MODE_CAPTURE: assert property (s_release |=> status_mode_active ==
    ($past(code_hit) || $past(reg_status_mode_req))) else $error("mode capture wrong");
  AST_MODE_HOLD: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
    $stable(status_mode_active))
    else $error("mode changed without reset");
  AST_SPEED_AMBER: assert property (speed_mode |=> &amber_port_lamp_n)
    else $error("amber lit in speed mode");
  AST_SUSPEND_OFF: assert property (speed_mode && hub_suspend |=> green_port_lamp_oe == '0)
    else $error("pin driven while suspended");
  AST_STATUS_DRIVE: assert property (status_mode_active |=> &green_port_lamp_oe)
    else $error("status pin released");
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    // Phase holds only across reset-free spans: square restarts at release
    AST_HIGH_WAVE: assert property (quiet >= HALF_CYCLES + 1
      && $past(live[p] && port_speed[p] == hpl_pkg::SPEED_HIGH)
      && $past(live[p] && port_speed[p] == hpl_pkg::SPEED_HIGH, HALF_CYCLES + 1) |->
      green_port_lamp_oe[p] && green_port_lamp_n[p] != $past(green_port_lamp_n[p], HALF_CYCLES))
      else $error("high speed wave wrong");
    AST_LOW_STEADY: assert property (live[p] && port_speed[p] == hpl_pkg::SPEED_LOW |=>
      green_port_lamp_oe[p] && !green_port_lamp_n[p]) else $error("low speed pin wrong");
    AST_FULL_STEADY: assert property (live[p] && port_speed[p] == hpl_pkg::SPEED_FULL |=>
      green_port_lamp_oe[p] && green_port_lamp_n[p]) else $error("full speed pin wrong");
    AST_UNPLUG_OFF: assert property (speed_mode && !port_connected[p] |=>
      !green_port_lamp_oe[p]) else $error("empty port driven");
    AST_STATUS_GREEN: assert property (status_mode_active && port_ind_sel[p] ==
      hpl_pkg::IND_GREEN |=> !green_port_lamp_n[p] && amber_port_lamp_n[p])
      else $error("green select wrong");
    AST_STATUS_AMBER: assert property (status_mode_active && port_ind_sel[p] ==
      hpl_pkg::IND_AMBER |=> green_port_lamp_n[p] && !amber_port_lamp_n[p])
      else $error("amber select wrong");
  end
endmodule

`default_nettype wire

//--- dv/hpl_lamp_board.sv
// Board lamps: resolves each pin and reports which colour glows
`timescale 1ns/1ns
`default_nettype none

module hpl_lamp_board #(
  parameter int NUM_PORTS = 7
)(
  input  wire logic                 clk,
  input  wire logic [NUM_PORTS-1:0] green_n,
  input  wire logic [NUM_PORTS-1:0] green_oe,
  input  wire logic [NUM_PORTS-1:0] amber_n,
  output logic [NUM_PORTS-1:0]      pin,
  output logic [NUM_PORTS-1:0]      green_lit,
  output logic [NUM_PORTS-1:0]      red_lit,
  output logic [NUM_PORTS-1:0]      amber_lit
);
  logic [NUM_PORTS-1:0] last;
  // No pull on the pin: a floating pin wanders instead of keeping its level
  always_ff @(posedge clk) last <= pin;
  assign pin = (green_oe & green_n) | (~green_oe & ~last);
  assign green_lit = green_oe & ~pin;
  assign red_lit = green_oe & pin;
  assign amber_lit = ~amber_n;
endmodule

`default_nettype wire

//--- dv/test_hpl_led_top.sv
// Self-checking bench for the lamp driver
`timescale 1ns/1ns
`default_nettype none

module test_hpl_led_top;
  localparam int NP = hpl_pkg::NUM_PORTS;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] cfg = 3'h0;
  logic req = 1'b0;
  logic susp = 1'b0;
  logic [NP-1:0] pwr = '0;
  logic [NP-1:0] con = '0;
  logic [NP-1:0] ena = '0;
  logic [NP-1:0] perr = '0;
  hpl_pkg::hpl_speed_t [NP-1:0] spd = '0;
  hpl_pkg::hpl_ind_t [NP-1:0] isel = '0;
  logic [NP-1:0] g_n, g_oe, a_n, pin, g_lit, r_lit, a_lit;
  logic mode_q;
  int err_total = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  hpl_led_top #(.NUM_PORTS(NP), .HALF_CYCLES(4)) DUT (.clk(clk), .sys_rst(sys_rst),
    .config_source_select_2(cfg[2]), .config_source_select_1(cfg[1]),
    .config_source_select_0(cfg[0]), .reg_status_mode_req(req), .hub_suspend(susp),
    .port_power(pwr), .port_connected(con), .port_enabled(ena), .port_error(perr),
    .port_speed(spd), .port_ind_sel(isel), .green_port_lamp_n(g_n),
    .green_port_lamp_oe(g_oe), .amber_port_lamp_n(a_n), .status_mode_active(mode_q));
  hpl_lamp_board #(.NUM_PORTS(NP)) u_board (.clk(clk), .green_n(g_n), .green_oe(g_oe),
    .amber_n(a_n), .pin(pin), .green_lit(g_lit), .red_lit(r_lit), .amber_lit(a_lit));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic restart(input logic [2:0] c, input logic r);
    sys_rst = 1'b1;
    cfg = c;
    req = r;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic scen_modes();
    logic exp;
    for (int c = 0; c < 8; c++)
    begin
      restart(3'(c), 1'b0);
      exp = (c == 2) || (c == 5) || (c == 7);
      chk(7'(mode_q), 7'(exp));
      cfg = ~cfg;
      req = 1'b1;
      repeat (3) @(negedge clk);
      chk(7'(mode_q), 7'(exp));
    end
    restart(3'h0, 1'b1);
    chk(7'(mode_q), 7'h01);
  endtask
  task automatic scen_speed();
    int edges;
    int highs;
    logic prev;
    restart(3'h0, 1'b0);
    pwr = '1;
    ena = '1;
    con = 7'h37;
    spd = {hpl_pkg::SPEED_LOW, hpl_pkg::SPEED_FULL, hpl_pkg::SPEED_HIGH, hpl_pkg::SPEED_LOW,
           hpl_pkg::SPEED_HIGH, hpl_pkg::SPEED_FULL, hpl_pkg::SPEED_LOW};
    isel = {NP{hpl_pkg::IND_GREEN}};
    repeat (2) @(negedge clk);
    chk(7'(g_lit[0]), 7'h01);
    chk(7'(r_lit[1]), 7'h01);
    chk(7'(g_oe[3]), 7'h00);
    chk(a_n, 7'h7f);
    edges = 0;
    highs = 0;
    prev = pin[2];
    repeat (16)
    begin
      @(negedge clk);
      highs += int'(pin[2]);
      edges += int'(pin[2] != prev);
      prev = pin[2];
    end
    chk(7'(edges), 7'h04);
    chk(7'(highs), 7'h08);
    susp = 1'b1;
    repeat (2) @(negedge clk);
    chk(g_oe, 7'h00);
    susp = 1'b0;
    con[2] = 1'b0;
    repeat (2) @(negedge clk);
    chk(7'(g_oe[2]), 7'h00);
  endtask
  task automatic scen_status();
    restart(3'h5, 1'b0);
    susp = 1'b1;
    spd = {NP{hpl_pkg::SPEED_HIGH}};
    pwr = 7'h77;
    con = 7'h60;
    ena = 7'h20;
    perr = 7'h10;
    isel = {hpl_pkg::IND_AUTO, hpl_pkg::IND_AUTO, hpl_pkg::IND_AUTO, hpl_pkg::IND_AUTO,
            hpl_pkg::IND_OFF, hpl_pkg::IND_AMBER, hpl_pkg::IND_GREEN};
    repeat (2) @(negedge clk);
    chk(g_oe, 7'h7f);
    chk(g_n, 7'h5e);
    chk(a_n, 7'h6d);
    repeat (5) @(negedge clk);
    chk(g_n, 7'h5e);
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    scen_modes();
    scen_speed();
    scen_status();
    tally_and_finish();
  end
  initial
  begin
    repeat (4000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
endmodule

bind hpl_led_top hpl_led_properties #(.NUM_PORTS(NUM_PORTS), .HALF_CYCLES(HALF_CYCLES)) u_props
(
  .clk(clk), .sys_rst(sys_rst), .config_source_select_2(config_source_select_2),
  .config_source_select_1(config_source_select_1),
  .config_source_select_0(config_source_select_0),
  .reg_status_mode_req(reg_status_mode_req), .hub_suspend(hub_suspend),
  .port_power(port_power), .port_connected(port_connected), .port_enabled(port_enabled),
  .port_error(port_error), .port_speed(port_speed), .port_ind_sel(port_ind_sel),
  .green_port_lamp_n(green_port_lamp_n), .green_port_lamp_oe(green_port_lamp_oe),
  .amber_port_lamp_n(amber_port_lamp_n), .status_mode_active(status_mode_active)
);

`default_nettype wire
